// *** rtl/pasl_pkg.sv ***
// shared constants and types for the address strap and status led pins
package pasl_pkg;

    // number of multiplexed strap / indicator pins
    localparam int unsigned NUM_PINS = 5;

    // address bit position of each pin
    localparam int unsigned BIT_ACTIVITY  = 0;
    localparam int unsigned BIT_COLLISION = 1;
    localparam int unsigned BIT_LINK      = 2;
    localparam int unsigned BIT_TX        = 3;
    localparam int unsigned BIT_RX        = 4;

    // reset values and the address that floats the interface
    localparam logic [NUM_PINS-1:0] ADDR_RST     = 5'h00;
    localparam logic [NUM_PINS-1:0] ADDR_ISOLATE = 5'h00;
    localparam logic                LED_RST      = 1'h0;
    localparam logic                HIZ_RST      = 1'h0;

    // pin phase: straps are read, then pins drive indicators
    typedef enum logic
    {
        PASL_SAMPLE = 1'b0,
        PASL_RUN    = 1'b1
    } pasl_mode_t;

endpackage : pasl_pkg

// *** rtl/pasl_pin_cell.sv ***
// one multiplexed pin: indicator output level and direction
`timescale 1ns/1ps

module pasl_pin_cell
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic quiet,
    input  wire logic strap,
    input  wire logic cond,
    output logic      pin_out,
    output logic      pin_oe
);

    // state of the cell
    typedef struct packed
    {
        logic drive;
    } pasl_cell_t;

    pasl_cell_t s_q;
    pasl_cell_t s_d;

    // asserted level is the inverse of the strap, idle level equals it
    always_comb
    begin
        s_d = s_q;
        s_d.drive = (run && !quiet && cond) ? ~strap : strap;
    end

    // register the drive level
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.drive <= pasl_pkg::LED_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.drive;
    assign pin_oe  = run; // input while straps are read, output after

endmodule // pasl_pin_cell

// *** rtl/pasl_strap_led.sv ***
// strap capture of the management address and status led drive on five shared pins
//
// Summary of operation
// - While power-on or hardware reset is held the five pins are inputs, read as reset ends.
// - At reset exit each pin level is stored into its bit of the management address.
// - Once the address is stored every pin turns into an output driving its indicator.
// - A software reset neither re-reads the pins nor turns them around, and keeps the address.
// - An output pin drives the inverse of its strap when asserted and the strap level otherwise.
// - Pins map to address bits 0..4 as activity, collision, link, transmit, receive.
// - A stored address of zero holds the media-independent interface outputs floating.
`timescale 1ns/1ps

module pasl_strap_led
(
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          sw_reset,
    input  wire logic                          status_activity,
    input  wire logic                          status_collision,
    input  wire logic                          status_link,
    input  wire logic                          status_tx,
    input  wire logic                          status_rx,
    input  wire logic                          addr_bit0_activity_led_in,
    output logic                               addr_bit0_activity_led_out,
    output logic                               addr_bit0_activity_led_oe,
    input  wire logic                          addr_bit1_collision_led_in,
    output logic                               addr_bit1_collision_led_out,
    output logic                               addr_bit1_collision_led_oe,
    input  wire logic                          addr_bit2_link_led_in,
    output logic                               addr_bit2_link_led_out,
    output logic                               addr_bit2_link_led_oe,
    input  wire logic                          addr_bit3_tx_led_in,
    output logic                               addr_bit3_tx_led_out,
    output logic                               addr_bit3_tx_led_oe,
    input  wire logic                          addr_bit4_rx_led_in,
    output logic                               addr_bit4_rx_led_out,
    output logic                               addr_bit4_rx_led_oe,
    output logic [pasl_pkg::NUM_PINS-1:0]      phy_addr,
    output logic                               strap_done,
    output logic                               mii_hiz
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin gathering

    logic [pasl_pkg::NUM_PINS-1:0] pin_in;
    logic [pasl_pkg::NUM_PINS-1:0] pin_out;
    logic [pasl_pkg::NUM_PINS-1:0] pin_oe;
    logic [pasl_pkg::NUM_PINS-1:0] cond;

    // pin and condition vectors in address-bit order
    always_comb
    begin
        pin_in = '0;
        cond   = '0;
        pin_in[pasl_pkg::BIT_ACTIVITY]  = addr_bit0_activity_led_in;
        pin_in[pasl_pkg::BIT_COLLISION] = addr_bit1_collision_led_in;
        pin_in[pasl_pkg::BIT_LINK]      = addr_bit2_link_led_in;
        pin_in[pasl_pkg::BIT_TX]        = addr_bit3_tx_led_in;
        pin_in[pasl_pkg::BIT_RX]        = addr_bit4_rx_led_in;
        cond[pasl_pkg::BIT_ACTIVITY]    = status_activity;
        cond[pasl_pkg::BIT_COLLISION]   = status_collision;
        cond[pasl_pkg::BIT_LINK]        = status_link;
        cond[pasl_pkg::BIT_TX]          = status_tx;
        cond[pasl_pkg::BIT_RX]          = status_rx;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // strap state

    typedef struct packed
    {
        pasl_pkg::pasl_mode_t          mode;
        logic [pasl_pkg::NUM_PINS-1:0] addr;
        logic                          hiz;
    } pasl_state_t;

    pasl_state_t s_q;
    pasl_state_t s_d;

    // first edge after reset release reads the pins, then the state freezes
    always_comb
    begin
        s_d = s_q;
        unique case (s_q.mode)
            pasl_pkg::PASL_SAMPLE:
            begin
                s_d.addr = pin_in;
                s_d.hiz  = (pin_in == pasl_pkg::ADDR_ISOLATE);
                s_d.mode = pasl_pkg::PASL_RUN;
            end
            pasl_pkg::PASL_RUN:
            begin
                s_d = s_q; // software reset has no say here
            end
        endcase
    end

    // only the hardware reset returns the pins to strap reading
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.mode <= pasl_pkg::PASL_SAMPLE;
            s_q.addr <= pasl_pkg::ADDR_RST;
            s_q.hiz  <= pasl_pkg::HIZ_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    logic run;

    assign run        = (s_q.mode == pasl_pkg::PASL_RUN);
    assign phy_addr   = s_q.addr;
    assign strap_done = run;
    assign mii_hiz    = s_q.hiz;

    ////////////////////////////////////////////////////////////////////////////////
    // per-pin drive cells

    genvar g;
    generate
        for (g = 0; g < pasl_pkg::NUM_PINS; g++)
        begin : g_pin
            pasl_pin_cell u_cell
            (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .run      (run),
                .quiet    (sw_reset),
                .strap    (s_d.addr[g]), // capture edge loads the new strap level
                .cond     (cond[g]),
                .pin_out  (pin_out[g]),
                .pin_oe   (pin_oe[g])
            );
        end
    endgenerate

    // spread vectors back onto the named pins
    assign addr_bit0_activity_led_out  = pin_out[pasl_pkg::BIT_ACTIVITY];
    assign addr_bit0_activity_led_oe   = pin_oe[pasl_pkg::BIT_ACTIVITY];
    assign addr_bit1_collision_led_out = pin_out[pasl_pkg::BIT_COLLISION];
    assign addr_bit1_collision_led_oe  = pin_oe[pasl_pkg::BIT_COLLISION];
    assign addr_bit2_link_led_out      = pin_out[pasl_pkg::BIT_LINK];
    assign addr_bit2_link_led_oe       = pin_oe[pasl_pkg::BIT_LINK];
    assign addr_bit3_tx_led_out        = pin_out[pasl_pkg::BIT_TX];
    assign addr_bit3_tx_led_oe         = pin_oe[pasl_pkg::BIT_TX];
    assign addr_bit4_rx_led_out        = pin_out[pasl_pkg::BIT_RX];
    assign addr_bit4_rx_led_oe         = pin_oe[pasl_pkg::BIT_RX];

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!rst_n);

    // pins stay inputs until the straps are read
    a_pins_input_sample: assert property (
        !run |-> (pin_oe == '0))
        else $error("strap pin driven before strap read");

    // address equals the pin levels seen on the capture edge
    a_addr_capture_edge: assert property (
        $rose(run) |-> (phy_addr == $past(pin_in)))
        else $error("address differs from sampled straps");

    // capture happens on the first edge after reset release
    a_capture_first_edge: assert property (
        !run |=> run)
        else $error("strap capture delayed");

    // all pins become outputs once straps are held
    a_pins_output_run: assert property (
        run |-> (pin_oe == {pasl_pkg::NUM_PINS{1'b1}}))
        else $error("pin not driving after strap read");

    // software reset keeps direction and address
    a_sw_reset_keep: assert property (
        (run && sw_reset) |=> (run && $stable(phy_addr) && (pin_oe == '1)))
        else $error("software reset disturbed strap state");

    // address never moves once captured
    a_addr_frozen_run: assert property (
        run ##1 run |-> $stable(phy_addr) [*4])
        else $error("address changed after capture");

    // drive level is strap xor condition, one cycle later
    a_led_level_drive: assert property (
        (run && !sw_reset) |=> (pin_out == (phy_addr ^ $past(cond))))
        else $error("indicator level wrong");

    // the capture edge already drives every indicator at its strap level
    a_led_idle_capture: assert property (
        $rose(run) |-> (pin_out == phy_addr))
        else $error("indicator not idle on strap capture");

    // software reset parks every indicator at its idle level
    a_sw_reset_idle: assert property (
        (run && sw_reset) |=> (pin_out == phy_addr))
        else $error("indicator not idle during software reset");

    // receive pin lands in the top address bit
    a_bit_order_rx: assert property (
        $rose(run) |-> (phy_addr[pasl_pkg::BIT_RX] == $past(addr_bit4_rx_led_in)))
        else $error("receive strap in wrong bit");

    // activity pin lands in the bottom address bit
    a_bit_order_act: assert property (
        $rose(run) |-> (phy_addr[pasl_pkg::BIT_ACTIVITY] == $past(addr_bit0_activity_led_in)))
        else $error("activity strap in wrong bit");

    // interface floats exactly when the address is zero
    a_mii_float_zero: assert property (
        run |-> (mii_hiz == (phy_addr == pasl_pkg::ADDR_ISOLATE)))
        else $error("interface float does not follow zero address");

    // collision indicator follows its own condition
    a_collision_follow: assert property (
        (run && !sw_reset && status_collision) |=>
            (addr_bit1_collision_led_out != phy_addr[pasl_pkg::BIT_COLLISION]))
        else $error("collision indicator not asserted");

endmodule // pasl_strap_led

// *** verif/pasl_board.sv ***
// board pull resistors in series with status leds on the five strap pins
`timescale 1ns/1ps

module pasl_board
(
    input  wire logic [4:0] pull_up,
    input  wire logic [4:0] pin_oe,
    input  wire logic [4:0] pin_out,
    output logic      [4:0] pin_level,
    output logic      [4:0] led_lit
);
    // a released pin settles to its pull level, a driven pin shows the drive
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : pull_up[i];
            led_lit[i]   = pin_oe[i] && (pin_out[i] != pull_up[i]); // current through the led
        end
    end
endmodule // pasl_board

// *** verif/pasl_strap_led_test.sv ***
// self-checking bench for the strap capture and status led pins
`timescale 1ns/1ps

module pasl_strap_led_test;
    logic       core_clk = 1'b0;
    logic       rst_n    = 1'b0;
    logic       sw_reset = 1'b0;
    logic [4:0] status   = 5'h00;
    logic [4:0] pull     = 5'h00;
    logic [4:0] strap;
    wire  [4:0] oe;
    wire  [4:0] out;
    wire  [4:0] pin;
    wire  [4:0] lit;
    wire  [4:0] phy_addr;
    wire        done;
    wire        hiz;
    int         fail_count = 0;
    int         compares   = 0;

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    pasl_strap_led dut
    (
        .core_clk(core_clk), .rst_n(rst_n), .sw_reset(sw_reset),
        .status_activity(status[0]), .status_collision(status[1]), .status_link(status[2]),
        .status_tx(status[3]), .status_rx(status[4]),
        .addr_bit0_activity_led_in(pin[0]), .addr_bit0_activity_led_out(out[0]),
        .addr_bit0_activity_led_oe(oe[0]),
        .addr_bit1_collision_led_in(pin[1]), .addr_bit1_collision_led_out(out[1]),
        .addr_bit1_collision_led_oe(oe[1]),
        .addr_bit2_link_led_in(pin[2]), .addr_bit2_link_led_out(out[2]),
        .addr_bit2_link_led_oe(oe[2]),
        .addr_bit3_tx_led_in(pin[3]), .addr_bit3_tx_led_out(out[3]),
        .addr_bit3_tx_led_oe(oe[3]),
        .addr_bit4_rx_led_in(pin[4]), .addr_bit4_rx_led_out(out[4]),
        .addr_bit4_rx_led_oe(oe[4]),
        .phy_addr(phy_addr), .strap_done(done), .mii_hiz(hiz)
    );

    pasl_board board
    (
        .pull_up(pull), .pin_oe(oe), .pin_out(out), .pin_level(pin), .led_lit(lit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // compare one pin-wide result
    task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // print counts and verdict, then stop
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hardware reset with given board straps, then check capture
    task automatic t_capture(input logic [4:0] s);
        strap    = s;
        pull     = s;
        status   = 5'h00;
        sw_reset = 1'b0;
        rst_n    = 1'b0;
        repeat (12) @(negedge core_clk);
        chk("oe_in_reset", 5'h00, oe);
        chk("done_in_reset", 5'h00, {4'h0, done});
        rst_n = 1'b1;
        @(negedge core_clk);
        chk("phy_addr", s, phy_addr);
        chk("oe_after", 5'h1f, oe);
        chk("out_after", s, out);
        chk("done_after", 5'h01, {4'h0, done});
        chk("mii_hiz", {4'h0, s == 5'h00}, {4'h0, hiz});
    endtask

    // each status condition lights only its own pin, inverse of strap
    task automatic t_indicate;
        for (int i = 0; i < 5; i++)
        begin
            status = 5'h01 << i;
            repeat (2) @(negedge core_clk);
            chk("led_on", strap ^ (5'h01 << i), out);
            chk("lit_on", 5'h01 << i, lit);
        end
        status = 5'h00;
        repeat (2) @(negedge core_clk);
        chk("led_off", strap, out);
    endtask

    // software reset idles leds but keeps direction and address
    task automatic t_sw_reset;
        status   = 5'h1f;
        sw_reset = 1'b1;
        pull     = ~strap;
        repeat (3) @(negedge core_clk);
        chk("sw_out", strap, out);
        chk("sw_oe", 5'h1f, oe);
        chk("sw_addr", strap, phy_addr);
        sw_reset = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("sw_after", ~strap, out);
        chk("sw_addr2", strap, phy_addr);
        pull = strap;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        t_capture(5'h0d);
        t_indicate;
        t_sw_reset;
        t_capture(5'h12);
        t_indicate;
        t_capture(5'h00);
        t_indicate;
        test_done;
    end

    // watchdog well beyond the expected run of about 80 cycles
    initial
    begin
        #(2000 * 50);
        fail_count++;
        test_done;
    end
endmodule // pasl_strap_led_test
